// ### logic/dld_dimming_regs.v
// Dimming generator configuration registers, width generator and measurement map
`timescale 1ns/1ps
`include "dld_regs.vh"

module dld_dimming_regs #(
    parameter CNT_W = 10
) (
    input  wire       REF_CLK,
    input  wire       NRST,
    input  wire [7:0] REG_ADDR,
    input  wire [7:0] REG_WDATA,
    input  wire       REG_WR,
    input  wire       REG_RD,
    output reg  [7:0] REG_RDATA,
    output reg        REG_RVALID,
    input  wire [9:0] ADC_RESULT,
    input  wire [3:0] ADC_INDEX,
    input  wire       ADC_VALID,
    output reg        DIM1_OUT,
    output reg        DIM2_OUT,
    output reg  [5:0] CH1_ON_TIME,
    output reg  [5:0] CH2_ON_TIME,
    output reg  [2:0] DIV_SELECT
);

// ----------------------------------------
// Conversion slot indices
// ----------------------------------------
localparam [3:0] IDX_CH1_VIN  = 4'h0;
localparam [3:0] IDX_CH1_VLED = 4'h1;
localparam [3:0] IDX_CH2_VIN  = 4'h4;
localparam [3:0] IDX_CH2_VLED = 4'h5;
localparam [3:0] IDX_TEMP_LO  = 4'h8;
localparam [3:0] IDX_TEMP_HI  = 4'h9;
localparam [3:0] IDX_DIG_RAIL = 4'ha;

localparam [CNT_W-1:0] CNT_LAST = {CNT_W{1'b1}};

// ----------------------------------------
// Helper functions
// ----------------------------------------
// Top eight bits of a conversion
function [7:0] upper_byte;
    input [9:0] res;
    begin
        upper_byte = res[`DLD_ADC_RES_MSB:`DLD_ADC_RES_LSB];
    end
endfunction

// Level of a channel for a counter value
function dim_level;
    input [CNT_W-1:0] cnt;
    input [CNT_W-1:0] width;
    begin
        dim_level = (cnt < width);
    end
endfunction

// ----------------------------------------
// Storage
// ----------------------------------------
reg  [7:0]       ch1_width_lo;
reg  [1:0]       ch1_width_hi;
reg  [7:0]       ch2_width_lo;
reg  [1:0]       ch2_width_hi;
reg  [CNT_W-1:0] ch1_width_live;
reg  [CNT_W-1:0] ch2_width_live;
reg              ch1_lo_seen;
reg              ch1_hi_seen;
reg              ch2_lo_seen;
reg              ch2_hi_seen;
reg  [CNT_W-1:0] period_cnt;
reg  [7:0]       ch1_vin;
reg  [7:0]       ch1_vled;
reg  [7:0]       ch1_lit;
reg  [7:0]       ch1_dark;
reg  [7:0]       ch2_vin;
reg  [7:0]       ch2_vled;
reg  [7:0]       ch2_lit;
reg  [7:0]       ch2_dark;
reg  [7:0]       temp_lo;
reg  [7:0]       temp_hi;
reg  [7:0]       dig_rail;
reg  [7:0]       next_rdata;

wire             dim_tick;
wire             period_end;
wire [CNT_W-1:0] next_cnt;
wire             ch1_load;
wire             ch2_load;
wire [CNT_W-1:0] ch1_width_use;
wire [CNT_W-1:0] ch2_width_use;
wire             next_dim1;
wire             next_dim2;
wire [7:0]       adc_byte;

// ----------------------------------------
// Write strobes
// ----------------------------------------
wire wr_div    = REG_WR && (REG_ADDR == `DLD_OFS_CLK_DIV);
wire wr_ch1_lo = REG_WR && (REG_ADDR == `DLD_OFS_CH1_WIDTH_LO);
wire wr_ch1_hi = REG_WR && (REG_ADDR == `DLD_OFS_CH1_WIDTH_HI);
wire wr_ch2_lo = REG_WR && (REG_ADDR == `DLD_OFS_CH2_WIDTH_LO);
wire wr_ch2_hi = REG_WR && (REG_ADDR == `DLD_OFS_CH2_WIDTH_HI);
wire wr_ch1_on = REG_WR && (REG_ADDR == `DLD_OFS_CH1_ON_TIME);
wire wr_ch2_on = REG_WR && (REG_ADDR == `DLD_OFS_CH2_ON_TIME);

// ----------------------------------------
// Dimming clock
// ----------------------------------------
// derived from block oscillator
dld_prescaler dld_prescaler_i (
    .clk   (REF_CLK),
    .rst_n (NRST),
    .sel   (DIV_SELECT),
    .tick  (dim_tick)
);

// ----------------------------------------
// Control registers
// ----------------------------------------
always @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
        DIV_SELECT   <= `DLD_RST_DIV_SEL;
        ch1_width_lo <= `DLD_RST_WIDTH_LO;
        ch1_width_hi <= `DLD_RST_WIDTH_HI;
        ch2_width_lo <= `DLD_RST_WIDTH_LO;
        ch2_width_hi <= `DLD_RST_WIDTH_HI;
        CH1_ON_TIME  <= `DLD_RST_ON_TIME;
        CH2_ON_TIME  <= `DLD_RST_ON_TIME;
    end else begin
        // select field bits 2 to 0
        if (wr_div) begin
            DIV_SELECT <= REG_WDATA[`DLD_DIV_SEL_MSB:0];
        end
        if (wr_ch1_lo) begin
            ch1_width_lo <= REG_WDATA;
        end
        if (wr_ch1_hi) begin
            ch1_width_hi <= REG_WDATA[`DLD_WIDTH_HI_MSB:0];
        end
        if (wr_ch2_lo) begin
            ch2_width_lo <= REG_WDATA;
        end
        if (wr_ch2_hi) begin
            ch2_width_hi <= REG_WDATA[`DLD_WIDTH_HI_MSB:0];
        end
        if (wr_ch1_on) begin
            CH1_ON_TIME <= REG_WDATA[`DLD_ON_TIME_MSB:0];
        end
        if (wr_ch2_on) begin
            CH2_ON_TIME <= REG_WDATA[`DLD_ON_TIME_MSB:0];
        end
    end
end

// ----------------------------------------
// Period counter
// ----------------------------------------
assign period_end = dim_tick && (period_cnt == CNT_LAST);
assign next_cnt   = dim_tick ? period_cnt + {{(CNT_W-1){1'b0}}, 1'b1} : period_cnt;

always @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
        period_cnt <= {CNT_W{1'b0}};
    end else begin
        period_cnt <= next_cnt;
    end
end

// ----------------------------------------
// Width staging
// ----------------------------------------
// A byte written in the load cycle arms the next load, so it is never lost
assign ch1_load = period_end && ch1_lo_seen && ch1_hi_seen;
assign ch2_load = period_end && ch2_lo_seen && ch2_hi_seen;
assign ch1_width_use = ch1_load ? {ch1_width_hi, ch1_width_lo} : ch1_width_live;
assign ch2_width_use = ch2_load ? {ch2_width_hi, ch2_width_lo} : ch2_width_live;

always @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
        ch1_lo_seen    <= 1'b0;
        ch1_hi_seen    <= 1'b0;
        ch2_lo_seen    <= 1'b0;
        ch2_hi_seen    <= 1'b0;
        ch1_width_live <= {CNT_W{1'b0}};
        ch2_width_live <= {CNT_W{1'b0}};
    end else begin
        ch1_lo_seen    <= wr_ch1_lo || (ch1_lo_seen && !ch1_load);
        ch1_hi_seen    <= wr_ch1_hi || (ch1_hi_seen && !ch1_load);
        ch2_lo_seen    <= wr_ch2_lo || (ch2_lo_seen && !ch2_load);
        ch2_hi_seen    <= wr_ch2_hi || (ch2_hi_seen && !ch2_load);
        ch1_width_live <= ch1_width_use;
        ch2_width_live <= ch2_width_use;
    end
end

// ----------------------------------------
// Dimming outputs
// ----------------------------------------
assign next_dim1 = dim_level(next_cnt, ch1_width_use);
assign next_dim2 = dim_level(next_cnt, ch2_width_use);

always @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
        DIM1_OUT <= 1'b0;
        DIM2_OUT <= 1'b0;
    end else begin
        DIM1_OUT <= next_dim1;
        DIM2_OUT <= next_dim2;
    end
end

// ----------------------------------------
// Measurement capture
// ----------------------------------------
// keep top eight result bits
assign adc_byte = upper_byte(ADC_RESULT);

always @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
        ch1_vin  <= `DLD_RST_RESULT;
        ch1_vled <= `DLD_RST_RESULT;
        ch2_vin  <= `DLD_RST_RESULT;
        ch2_vled <= `DLD_RST_RESULT;
        temp_lo  <= `DLD_RST_RESULT;
        temp_hi  <= `DLD_RST_RESULT;
        dig_rail <= `DLD_RST_RESULT;
    end else if (ADC_VALID) begin
        case (ADC_INDEX)
            IDX_CH1_VIN: begin
                ch1_vin <= adc_byte;
            end
            IDX_CH1_VLED: begin
                ch1_vled <= adc_byte;
            end
            IDX_CH2_VIN: begin
                ch2_vin <= adc_byte;
            end
            IDX_CH2_VLED: begin
                ch2_vled <= adc_byte;
            end
            IDX_TEMP_LO: begin
                temp_lo <= adc_byte;
            end
            IDX_TEMP_HI: begin
                temp_hi <= adc_byte;
            end
            IDX_DIG_RAIL: begin
                dig_rail <= adc_byte;
            end
            default: begin
                dig_rail <= dig_rail;
            end
        endcase
    end
end

// Lit and dark slots copy the latest LED reading at the edge, so they
// show the level that held just before the output switched
// capture before falling and rising edges
always @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
        ch1_lit  <= `DLD_RST_RESULT;
        ch1_dark <= `DLD_RST_RESULT;
        ch2_lit  <= `DLD_RST_RESULT;
        ch2_dark <= `DLD_RST_RESULT;
    end else begin
        if (DIM1_OUT && !next_dim1) begin
            ch1_lit <= ch1_vled;
        end
        if (!DIM1_OUT && next_dim1) begin
            ch1_dark <= ch1_vled;
        end
        if (DIM2_OUT && !next_dim2) begin
            ch2_lit <= ch2_vled;
        end
        if (!DIM2_OUT && next_dim2) begin
            ch2_dark <= ch2_vled;
        end
    end
end

// ----------------------------------------
// Read mux
// ----------------------------------------
// reserved bits read zero
// high width bits 7 to 2 read zero
always @* begin
    case (REG_ADDR)
        `DLD_OFS_CLK_DIV:      next_rdata = {5'h00, DIV_SELECT};
        `DLD_OFS_CH1_WIDTH_LO: next_rdata = ch1_width_lo;
        `DLD_OFS_CH1_WIDTH_HI: next_rdata = {6'h00, ch1_width_hi};
        `DLD_OFS_CH2_WIDTH_LO: next_rdata = ch2_width_lo;
        `DLD_OFS_CH2_WIDTH_HI: next_rdata = {6'h00, ch2_width_hi};
        `DLD_OFS_CH1_ON_TIME:  next_rdata = {2'h0, CH1_ON_TIME};
        `DLD_OFS_CH2_ON_TIME:  next_rdata = {2'h0, CH2_ON_TIME};
        `DLD_OFS_CH1_VIN:      next_rdata = ch1_vin;
        `DLD_OFS_CH1_VLED:     next_rdata = ch1_vled;
        `DLD_OFS_CH1_LIT:      next_rdata = ch1_lit;
        `DLD_OFS_CH1_DARK:     next_rdata = ch1_dark;
        `DLD_OFS_CH2_VIN:      next_rdata = ch2_vin;
        `DLD_OFS_CH2_VLED:     next_rdata = ch2_vled;
        `DLD_OFS_CH2_LIT:      next_rdata = ch2_lit;
        `DLD_OFS_CH2_DARK:     next_rdata = ch2_dark;
        `DLD_OFS_TEMP_LO:      next_rdata = temp_lo;
        `DLD_OFS_TEMP_HI:      next_rdata = temp_hi;
        `DLD_OFS_DIG_RAIL:     next_rdata = dig_rail;
        default:               next_rdata = 8'h00;
    endcase
end

// Read data is held until the next read so a slow host can sample it
always @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
        REG_RDATA  <= 8'h00;
        REG_RVALID <= 1'b0;
    end else begin
        REG_RVALID <= REG_RD;
        if (REG_RD) begin
            REG_RDATA <= next_rdata;
        end
    end
end

endmodule

// ### logic/dld_regs.vh
// Register map, field layout, reset values and timing constants
`ifndef DLD_REGS_VH
`define DLD_REGS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define DLD_OFS_CLK_DIV        8'h0c
`define DLD_OFS_CH1_WIDTH_LO   8'h0d
`define DLD_OFS_CH1_WIDTH_HI   8'h0e
`define DLD_OFS_CH2_WIDTH_LO   8'h0f
`define DLD_OFS_CH2_WIDTH_HI   8'h10
`define DLD_OFS_CH1_ON_TIME    8'h11
`define DLD_OFS_CH2_ON_TIME    8'h12
`define DLD_OFS_CH1_VIN        8'h13
`define DLD_OFS_CH1_VLED       8'h14
`define DLD_OFS_CH1_LIT        8'h15
`define DLD_OFS_CH1_DARK       8'h16
`define DLD_OFS_CH2_VIN        8'h17
`define DLD_OFS_CH2_VLED       8'h18
`define DLD_OFS_CH2_LIT        8'h19
`define DLD_OFS_CH2_DARK       8'h1a
`define DLD_OFS_TEMP_LO        8'h1b
`define DLD_OFS_TEMP_HI        8'h1c
`define DLD_OFS_DIG_RAIL       8'h1d

// ----------------------------------------
// Field positions and widths
// ----------------------------------------
`define DLD_DIV_SEL_MSB        2
`define DLD_WIDTH_HI_MSB       1
`define DLD_ON_TIME_MSB        5
`define DLD_ADC_RES_MSB        9
`define DLD_ADC_RES_LSB        2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define DLD_RST_DIV_SEL        3'h4
`define DLD_RST_WIDTH_LO       8'h00
`define DLD_RST_WIDTH_HI       2'h0
`define DLD_RST_ON_TIME        6'h07
`define DLD_RST_RESULT         8'h00

// ----------------------------------------
// Divider ratios per select code
// ----------------------------------------
`define DLD_DIV_CODE0          7'd7
`define DLD_DIV_CODE1          7'd8
`define DLD_DIV_CODE2          7'd10
`define DLD_DIV_CODE3          7'd12
`define DLD_DIV_CODE4          7'd16
`define DLD_DIV_CODE5          7'd24
`define DLD_DIV_CODE6          7'd49
`define DLD_DIV_CODE7          7'd98
`define DLD_OSC_FREQ_KHZ       10800

`endif

// ### logic/dld_prescaler.v
// Dimming clock prescaler: one tick per selected number of oscillator cycles
`timescale 1ns/1ps
`include "dld_regs.vh"

module dld_prescaler (
    input  wire       clk,
    input  wire       rst_n,
    input  wire [2:0] sel,
    output reg        tick
);

// ----------------------------------------
// Ratio lookup
// ----------------------------------------
function [6:0] ratio;
    input [2:0] code;
    begin
        case (code)
            3'h0: ratio = `DLD_DIV_CODE0;
            3'h1: ratio = `DLD_DIV_CODE1;
            3'h2: ratio = `DLD_DIV_CODE2;
            3'h3: ratio = `DLD_DIV_CODE3;
            3'h4: ratio = `DLD_DIV_CODE4;
            3'h5: ratio = `DLD_DIV_CODE5;
            3'h6: ratio = `DLD_DIV_CODE6;
            default: ratio = `DLD_DIV_CODE7;
        endcase
    end
endfunction

reg  [6:0] count;
reg  [2:0] sel_seen;
wire [6:0] last = ratio(sel) - 7'h01;

// ----------------------------------------
// Divider counter
// ----------------------------------------
// ratio from select code
// A select change restarts the count, so the first tick after it comes a full new ratio later
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        count    <= 7'h00;
        sel_seen <= `DLD_RST_DIV_SEL;
        tick     <= 1'b0;
    end else begin
        sel_seen <= sel;
        if (sel != sel_seen || count >= last) begin
            count <= 7'h00;
        end else begin
            count <= count + 7'h01;
        end
        tick <= (sel == sel_seen) && (count >= last);
    end
end

endmodule

// ### tb/dld_regs_props.sv
// Port checker for the dimming register block
`timescale 1ns/1ps
module dld_regs_props #(
    parameter CNT_W = 10
) (
    input wire       REF_CLK,
    input wire       NRST,
    input wire [7:0] REG_ADDR,
    input wire [7:0] REG_WDATA,
    input wire       REG_WR,
    input wire       REG_RD,
    input wire [7:0] REG_RDATA,
    input wire       REG_RVALID,
    input wire [9:0] ADC_RESULT,
    input wire [3:0] ADC_INDEX,
    input wire       ADC_VALID,
    input wire       DIM1_OUT,
    input wire       DIM2_OUT,
    input wire [5:0] CH1_ON_TIME,
    input wire [5:0] CH2_ON_TIME,
    input wire [2:0] DIV_SELECT
);
    reg  [7:0] vin1;
    reg  [7:0] rd_a;
    wire       wr_div = REG_WR && REG_ADDR == 8'h0c;
    wire       wr_t1  = REG_WR && REG_ADDR == 8'h11;
    wire       wr_t2  = REG_WR && REG_ADDR == 8'h12;

    // Mirrors of the last read address and the first conversion slot
    always @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            vin1 <= 8'h00;
            rd_a <= 8'h00;
        end else begin
            if (ADC_VALID && ADC_INDEX == 4'h0)
                vin1 <= ADC_RESULT[9:2];
            if (REG_RD)
                rd_a <= REG_ADDR;
        end
    end

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!NRST);

    a_read_answer: assert property (REG_RD |=> REG_RVALID)
        else $error("read not answered");
    a_div_write: assert property (wr_div |=> DIV_SELECT == $past(REG_WDATA[2:0]))
        else $error("divider select not taken");
    a_div_hold: assert property (!wr_div |=> $stable(DIV_SELECT))
        else $error("divider select moved");
    a_ton1_write: assert property (wr_t1 |=> CH1_ON_TIME == $past(REG_WDATA[5:0]))
        else $error("on-time one not taken");
    a_ton2_write: assert property (wr_t2 |=> CH2_ON_TIME == $past(REG_WDATA[5:0]))
        else $error("on-time two not taken");
    a_div_reserved: assert property (REG_RVALID && rd_a == 8'h0c |-> REG_RDATA[7:3] == 5'h00)
        else $error("divider reserved bits set");
    a_high_reserved: assert property (REG_RVALID && (rd_a == 8'h0e || rd_a == 8'h10)
        |-> REG_RDATA[7:2] == 6'h00)
        else $error("width high reserved bits set");
    a_unmapped_zero: assert property (REG_RVALID && (rd_a < 8'h0c || rd_a > 8'h1d)
        |-> REG_RDATA == 8'h00)
        else $error("unmapped read not zero");
    a_vin_capture: assert property (REG_RVALID && rd_a == 8'h13 |-> REG_RDATA == $past(vin1))
        else $error("input reading wrong");
    a_dim_spacing: assert property ($changed(DIM1_OUT) |=> $stable(DIM1_OUT) [*6])
        else $error("dimming output changed too soon");

    c_div_write: cover property (wr_div);
    c_dim_fall: cover property ($fell(DIM1_OUT));
    c_adc_slot: cover property (ADC_VALID && ADC_INDEX == 4'h1);
endmodule

bind dld_dimming_regs dld_regs_props #(.CNT_W(CNT_W)) props_i (
    .REF_CLK(REF_CLK), .NRST(NRST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID),
    .ADC_RESULT(ADC_RESULT), .ADC_INDEX(ADC_INDEX), .ADC_VALID(ADC_VALID),
    .DIM1_OUT(DIM1_OUT), .DIM2_OUT(DIM2_OUT), .CH1_ON_TIME(CH1_ON_TIME),
    .CH2_ON_TIME(CH2_ON_TIME), .DIV_SELECT(DIV_SELECT));

// ### tb/dld_host_model.sv
// Host side master for the block's register port
`timescale 1ns/1ps
module dld_host_model (
    input  wire       REF_CLK,
    output reg  [7:0] REG_ADDR,
    output reg  [7:0] REG_WDATA,
    output reg        REG_WR,
    output reg        REG_RD,
    input  wire [7:0] REG_RDATA
);
    initial begin
        REG_ADDR = 8'h00;
        REG_WDATA = 8'h00;
        REG_WR = 1'b0;
        REG_RD = 1'b0;
    end

    // Idle bus shows inverted values so nothing leans on a held address
    task release_bus;
        begin
            REG_WR = 1'b0;
            REG_RD = 1'b0;
            REG_ADDR = ~REG_ADDR;
            REG_WDATA = ~REG_WDATA;
        end
    endtask

    task wr(input [7:0] a, input [7:0] d);
        begin
            @(posedge REF_CLK) #1;
            REG_ADDR = a;
            REG_WDATA = d;
            REG_WR = 1'b1;
            @(posedge REF_CLK) #1;
            release_bus;
        end
    endtask

    task rd(input [7:0] a, output [7:0] d);
        begin
            @(posedge REF_CLK) #1;
            REG_ADDR = a;
            REG_RD = 1'b1;
            @(posedge REF_CLK) #1;
            release_bus;
            d = REG_RDATA;
        end
    endtask
endmodule

// ### tb/dld_dimming_regs_bench.sv
// Self-checking bench for the dimming register block
`timescale 1ns/1ps
module dld_dimming_regs_bench;
    reg        REF_CLK;
    reg        NRST;
    reg  [9:0] ADC_RESULT;
    reg  [3:0] ADC_INDEX;
    reg        ADC_VALID;
    wire [7:0] REG_ADDR;
    wire [7:0] REG_WDATA;
    wire [7:0] REG_RDATA;
    wire       REG_WR;
    wire       REG_RD;
    wire       REG_RVALID;
    wire       DIM1_OUT;
    wire       DIM2_OUT;
    wire [5:0] CH1_ON_TIME;
    wire [5:0] CH2_ON_TIME;
    wire [2:0] DIV_SELECT;
    integer    mismatches;
    integer    checks;
    integer    cyc;
    integer    i;
    integer    n1;
    integer    n2;
    reg  [7:0] d;
    reg  [7:0] exp_reg [0:31];
    localparam [55:0] RAT = {7'd98, 7'd49, 7'd24, 7'd16, 7'd12, 7'd10, 7'd8, 7'd7};

    dld_dimming_regs #(.CNT_W(10)) dld_dimming_regs_i (
        .REF_CLK(REF_CLK), .NRST(NRST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
        .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID),
        .ADC_RESULT(ADC_RESULT), .ADC_INDEX(ADC_INDEX), .ADC_VALID(ADC_VALID),
        .DIM1_OUT(DIM1_OUT), .DIM2_OUT(DIM2_OUT), .CH1_ON_TIME(CH1_ON_TIME),
        .CH2_ON_TIME(CH2_ON_TIME), .DIV_SELECT(DIV_SELECT));
    dld_host_model dld_host_model_i (
        .REF_CLK(REF_CLK), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
        .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA));

    function [7:0] mask(input [7:0] a);
        case (a)
            8'h0c: mask = 8'h07;
            8'h0d, 8'h0f: mask = 8'hff;
            8'h0e, 8'h10: mask = 8'h03;
            8'h11, 8'h12: mask = 8'h3f;
            default: mask = 8'h00;
        endcase
    endfunction

    function [7:0] slot(input [3:0] x);
        case (x)
            4'h0: slot = 8'h13;
            4'h1: slot = 8'h14;
            4'h4: slot = 8'h17;
            4'h5: slot = 8'h18;
            4'h8: slot = 8'h1b;
            4'h9: slot = 8'h1c;
            4'ha: slot = 8'h1d;
            default: slot = 8'h00;
        endcase
    endfunction

    function [15:0] per(input integer c);
        per = {9'h000, RAT[c*7 +: 7]};
    endfunction

    function dimv(input integer ch);
        dimv = (ch == 1) ? DIM1_OUT : DIM2_OUT;
    endfunction

    task check(input [15:0] seen, input [15:0] want);
        begin
            checks = checks + 1;
            if (seen !== want) begin
                mismatches = mismatches + 1;
                $display("MISMATCH at %0t: seen %h expected %h", $time, seen, want);
            end
        end
    endtask

    task conclude;
        begin
            $display("checks %0d mismatches %0d", checks, mismatches);
            if (mismatches == 0 && checks > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask

    task w(input [7:0] a, input [7:0] v);
        begin
            dld_host_model_i.wr(a, v);
            if (mask(a) != 8'h00)
                exp_reg[a[4:0]] = v & mask(a);
        end
    endtask

    task sweep;
        begin
            for (i = 0; i < 32; i = i + 1) begin
                dld_host_model_i.rd(i[7:0], d);
                check(d, exp_reg[i]);
            end
        end
    endtask

    task adc(input [3:0] x, input [9:0] r);
        begin
            @(posedge REF_CLK) #1;
            ADC_INDEX = x;
            ADC_RESULT = r;
            ADC_VALID = 1'b1;
            @(posedge REF_CLK) #1;
            ADC_VALID = 1'b0;
            if (slot(x) != 8'h00)
                exp_reg[slot(x)] = r[9:2];
        end
    endtask

    // Length of the next run at level lvl, in clock cycles
    task automatic meas(input integer ch, input lvl, output integer n);
        begin
            n = 0;
            while (dimv(ch) === lvl)
                @(posedge REF_CLK) #1;
            while (dimv(ch) !== lvl)
                @(posedge REF_CLK) #1;
            while (dimv(ch) === lvl) begin
                n = n + 1;
                @(posedge REF_CLK) #1;
            end
        end
    endtask

    task pulses(input [15:0] h1, input [15:0] l2, input chk);
        begin
            fork
                meas(1, 1'b1, n1);
                meas(2, 1'b0, n2);
            join
            if (chk) begin
                check(n1[15:0], h1);
                check(n2[15:0], l2);
            end
        end
    endtask

    initial begin
        REF_CLK = 1'b0;
        forever #5 REF_CLK = ~REF_CLK;
    end

    // Hang guard sized above the longest dimming period sequence
    always @(posedge REF_CLK) begin
        cyc = cyc + 1;
        if (cyc == 90000) begin
            mismatches = mismatches + 1;
            conclude;
        end
    end

    initial begin
        NRST = 1'b0;
        ADC_RESULT = 10'h000;
        ADC_INDEX = 4'h0;
        ADC_VALID = 1'b0;
        mismatches = 0;
        checks = 0;
        cyc = 0;
        for (i = 0; i < 32; i = i + 1)
            exp_reg[i] = 8'h00;
        exp_reg[12] = 8'h04;
        exp_reg[17] = 8'h07;
        exp_reg[18] = 8'h07;
        void'($urandom(78740));
        repeat (4) @(posedge REF_CLK);
        #1 NRST = 1'b1;
        check(DIV_SELECT, 3'h4);
        check(CH1_ON_TIME, 6'h07);
        check(CH2_ON_TIME, 6'h07);
        sweep;
        for (i = 0; i < 16; i = i + 1)
            adc(i[3:0], 10'($urandom));
        for (i = 0; i < 32; i = i + 1)
            w(i[7:0], 8'($urandom));
        sweep;
        check(CH1_ON_TIME, exp_reg[17][5:0]);
        check(CH2_ON_TIME, exp_reg[18][5:0]);
        for (i = 0; i < 8; i = i + 1) begin
            w(8'h0c, i[7:0]);
            check(DIV_SELECT, i[2:0]);
        end
        adc(4'h1, 10'h2a5);
        adc(4'h5, 10'h15a);
        w(8'h0c, 8'h00);
        w(8'h0d, 8'h01);
        w(8'h0e, 8'h00);
        w(8'h0f, 8'hff);
        w(8'h10, 8'h03);
        pulses(16'd7, 16'd7, 1'b0);
        pulses(16'd7, 16'd7, 1'b1);
        // Low byte alone must not change the running width
        w(8'h0d, 8'h03);
        pulses(16'd7, 16'd7, 1'b1);
        w(8'h0e, 8'h00);
        pulses(16'd21, 16'd7, 1'b0);
        pulses(16'd21, 16'd7, 1'b1);
        for (i = 1; i < 3; i = i + 1) begin
            w(8'h0c, i[7:0]);
            pulses(16'd0, 16'd0, 1'b0);
            pulses(16'(3 * per(i)), per(i), 1'b1);
        end
        exp_reg[21] = exp_reg[20];
        exp_reg[22] = exp_reg[20];
        exp_reg[25] = exp_reg[24];
        exp_reg[26] = exp_reg[24];
        sweep;
        conclude;
    end
endmodule
